/* File: core/adc_pair_pkg.sv */
/*
  Constants, register map and types for the paired-channel converter control block.
  Assumes a 16-bit register port with word-aligned byte addresses and one 250 MHz clock.
*/
package adc_pair_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PAIRS = 6;
  localparam int CHANNELS = 12;
  localparam int RESULT_W = 10;
  localparam int TRIG_W = 5;
  localparam int TRIG_SRCS = 32;
  localparam int DIV_W = 3;
  localparam int DIVCNT_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BASE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PORTCFG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PAIRCTL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h40;

  // Control register fields
  localparam int CTRL_POWER = 15;
  localparam int CTRL_IDLE_STOP = 13;
  localparam int CTRL_GTRG = 10;
  localparam int CTRL_LAYOUT = 8;
  localparam int CTRL_EARLY = 7;
  localparam int CTRL_ORDER = 6;
  localparam int CTRL_SEQUENTIAL_SAMPLING = 5;
  localparam int CTRL_DIV_LSB = 0;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 16'ha5e7;

  // Pair control fields, per byte lane (two pairs per register)
  localparam int PC_TRG_LSB = 0;
  localparam int PC_SOFT = 5;
  localparam int PC_PEND = 6;
  localparam int PC_IRQEN = 7;
  localparam int PC_LANE = 8;

  // Trigger select codes
  localparam logic [TRIG_W-1:0] TRIG_NONE = 5'h00;
  localparam logic [TRIG_W-1:0] TRIG_SOFT = 5'h01;
  localparam logic [TRIG_W-1:0] TRIG_GLOBAL = 5'h02;
  localparam logic [TRIG_W-1:0] TRIG_HW_FIRST = 5'h03;
  localparam logic [TRIG_W-1:0] TRIG_TIMER1_PERIOD = 5'h0c;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BASE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PORTCFG_RESET = 16'h0000;

  // Timing: conversion clock ticks per pair and per channel
  localparam int CONV_TICKS_PER_PAIR = 24;
  localparam int CONV_TICKS_PER_CH = CONV_TICKS_PER_PAIR / 2;
  localparam logic [3:0] CH_LAST_TICK = 4'(CONV_TICKS_PER_CH - 1);
  localparam logic [DIVCNT_W-1:0] DIV_BIAS = 5'h04;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND
  } seq_state_t;

  // Input clock cycles per conversion clock: 2 * (divider + 2)
  function automatic logic [DIVCNT_W-1:0] div_period(input logic [DIV_W-1:0] div);
    div_period = {1'b0, div, 1'b0} + DIV_BIAS;
  endfunction

endpackage

/* File: core/conv_clock_gen.sv */
/*
  Conversion clock tick generator dividing the module clock.
  Assumes the divider setting is stable while enabled.
*/
`timescale 1ns/1ns
module conv_clock_gen (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  input wire logic [adc_pair_pkg::DIV_W-1:0] i_divider,
  // Tick
  output logic o_tick
);
  import adc_pair_pkg::*;

  typedef struct packed {
    logic [DIVCNT_W-1:0] count;
    logic tick;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!i_enable) begin
      state_next.count = '0;
    end else if (state_reg.count == div_period(i_divider) - 5'h01) begin
      state_next.count = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 5'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_tick = state_reg.tick;

endmodule // conv_clock_gen

/* File: core/adc_pair_trigger_status_ctrl.sv */
/*
  Control and status logic for a paired-channel successive-approximation converter:
  registers, trigger handling, pair sequencing, interrupts and result buffer.
  Assumes the analog core presents a settled result on i_conv_result at the end of
  each channel's conversion window, and that triggers are single-cycle pulses in the
  module clock domain.
*/
`timescale 1ns/1ns
module adc_pair_trigger_status_ctrl (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port
  input wire logic [adc_pair_pkg::ADDR_W-1:0] i_addr,
  input wire logic [adc_pair_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [adc_pair_pkg::DATA_W-1:0] o_rd_data,
  // Hardware trigger sources
  input wire logic [adc_pair_pkg::TRIG_SRCS-1:0] i_trigger_sources,
  // Power state
  input wire logic i_cpu_idle,
  // Analog core
  input wire logic [adc_pair_pkg::RESULT_W-1:0] i_conv_result,
  output logic o_conv_active,
  output logic [3:0] o_conv_channel,
  output logic o_conv_clock_tick,
  // Pins and interrupt
  output logic [adc_pair_pkg::CHANNELS-1:0] o_analog_select,
  output logic o_conversion_irq_flag
);
  import adc_pair_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [PAIRS-1:0] soft_trg;
    logic [PAIRS-1:0] pend;
    logic [PAIRS-1:0] ready;
    logic [PAIRS-1:0] irq_en;
    logic [PAIRS-1:0][TRIG_W-1:0] trg_sel;
    logic [DATA_W-1:0] base;
    logic [DATA_W-1:0] port_cfg;
    logic [2:0] vec_pair;
    logic [2:0] act_pair;
    seq_state_t state;
    logic [3:0] ticks;
    logic [DATA_W-1:0] rd_data;
    logic irq;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;

  // Result buffer, deliberately without reset
  logic [RESULT_W-1:0] result_buffer [CHANNELS];
  logic buf_we;
  logic [3:0] buf_ch;
  logic running;
  logic conv_tick;
  logic [3:0] cur_ch;

  // Index of a pair control register, or 2'h3 when not one
  function automatic logic [1:0] pair_reg_index(input logic [ADDR_W-1:0] addr);
    if (addr == OFF_PAIRCTL) begin
      pair_reg_index = 2'h0;
    end else if (addr == OFF_PAIRCTL + 8'h04) begin
      pair_reg_index = 2'h1;
    end else if (addr == OFF_PAIRCTL + 8'h08) begin
      pair_reg_index = 2'h2;
    end else begin
      pair_reg_index = 2'h3;
    end
  endfunction

  function automatic logic is_result(input logic [ADDR_W-1:0] addr);
    is_result = (addr >= OFF_RESULT) && (addr < OFF_RESULT + 8'(4 * CHANNELS))
      && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] result_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFF_RESULT;
    result_index = rel[5:2];
  endfunction

  function automatic logic [2:0] lowest_pending(input logic [PAIRS-1:0] pend);
    lowest_pending = 3'h0;
    for (int p = PAIRS - 1; p >= 0; p--) begin
      if (pend[p]) begin
        lowest_pending = 3'(p);
      end
    end
  endfunction

  conv_clock_gen u_conv_clock_gen (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_enable(running && (state_reg.state != ST_IDLE)),
    .i_divider(state_reg.ctrl[CTRL_DIV_LSB +: DIV_W]),
    .o_tick(conv_tick)
  );

  // Halted when off, or in Idle with idle-stop selected
  assign running = state_reg.ctrl[CTRL_POWER]
    && !(state_reg.ctrl[CTRL_IDLE_STOP] && i_cpu_idle);

  // Even channel first unless order bit set
  assign cur_ch = {state_reg.act_pair, 1'b0}
    | 4'((state_reg.state == ST_FIRST) ? state_reg.ctrl[CTRL_ORDER]
                                       : !state_reg.ctrl[CTRL_ORDER]);

  always_comb begin
    logic [1:0] pidx;
    logic [PAIRS-1:0] soft_set;
    logic gtrg_set;
    logic raise;
    logic [TRIG_W-1:0] sel;
    logic hit;
    logic [RESULT_W-1:0] rv;
    pidx = pair_reg_index(i_addr);
    soft_set = '0;
    gtrg_set = 1'b0;
    raise = 1'b0;
    sel = '0;
    hit = 1'b0;
    rv = '0;
    buf_we = 1'b0;
    buf_ch = cur_ch;
    state_next = state_reg;
    state_next.rd_data = '0;
    state_next.irq = 1'b0;

    // Software writes
    if (i_wr_en) begin
      if (i_addr == OFF_CTRL) begin
        state_next.ctrl = i_wr_data & CTRL_WMASK;
        gtrg_set = i_wr_data[CTRL_GTRG];
      end else if (i_addr == OFF_STATUS) begin
        // Writing 0 clears a ready bit, writing 1 leaves it
        state_next.ready = state_reg.ready & i_wr_data[PAIRS-1:0];
      end else if (i_addr == OFF_BASE) begin
        state_next.base = i_wr_data;
      end else if (i_addr == OFF_PORTCFG) begin
        state_next.port_cfg = i_wr_data;
      end else if (pidx != 2'h3) begin
        for (int h = 0; h < 2; h++) begin
          state_next.trg_sel[pidx * 2 + h] = i_wr_data[h * PC_LANE + PC_TRG_LSB +: TRIG_W];
          state_next.irq_en[pidx * 2 + h] = i_wr_data[h * PC_LANE + PC_IRQEN];
          state_next.soft_trg[pidx * 2 + h] = i_wr_data[h * PC_LANE + PC_SOFT];
          soft_set[pidx * 2 + h] = i_wr_data[h * PC_LANE + PC_SOFT];
        end
      end
    end

    // Pair sequencer
    case (state_reg.state)
      ST_IDLE: begin
        if (running && (|state_reg.pend)) begin
          state_next.act_pair = lowest_pending(state_reg.pend);
          state_next.state = ST_FIRST;
          state_next.ticks = '0;
        end
      end
      ST_FIRST, ST_SECOND: begin
        if (!running) begin
          // Abort; the partial pair is dropped, not resumed
          state_next.state = ST_IDLE;
          state_next.pend[state_reg.act_pair] = 1'b0;
        end else if (conv_tick) begin
          if (state_reg.ticks == CH_LAST_TICK) begin
            buf_we = 1'b1;
            state_next.ticks = '0;
            if (state_reg.state == ST_FIRST) begin
              state_next.state = ST_SECOND;
              raise = state_reg.ctrl[CTRL_EARLY];
            end else begin
              state_next.state = ST_IDLE;
              state_next.pend[state_reg.act_pair] = 1'b0;
              raise = !state_reg.ctrl[CTRL_EARLY];
            end
          end else begin
            state_next.ticks = state_reg.ticks + 4'h1;
          end
        end
      end
      default: begin
        state_next.state = ST_IDLE;
      end
    endcase

    // Interrupt raise, blocked while the pair's ready bit is set
    if (raise && !state_reg.ready[state_reg.act_pair]) begin
      state_next.ready[state_reg.act_pair] = 1'b1;
      state_next.vec_pair = state_reg.act_pair;
      state_next.irq = state_reg.irq_en[state_reg.act_pair];
    end

    // Trigger acceptance; nothing changes while halted
    if (running) begin
      for (int p = 0; p < PAIRS; p++) begin
        sel = state_reg.trg_sel[p];
        hit = state_reg.soft_trg[p]
          || ((sel == TRIG_GLOBAL) && state_reg.ctrl[CTRL_GTRG])
          || ((sel >= TRIG_HW_FIRST) && i_trigger_sources[sel]);
        if (hit) begin
          state_next.pend[p] = 1'b1;
          if (!soft_set[p]) begin
            state_next.soft_trg[p] = 1'b0;
          end
        end
      end
      if (state_reg.ctrl[CTRL_GTRG] && !gtrg_set) begin
        state_next.ctrl[CTRL_GTRG] = 1'b0;
      end
    end

    // Register reads, answered the next cycle
    if (i_rd_en) begin
      if (i_addr == OFF_CTRL) begin
        state_next.rd_data = state_reg.ctrl;
      end else if (i_addr == OFF_STATUS) begin
        state_next.rd_data = {{(DATA_W - PAIRS){1'b0}}, state_reg.ready};
      end else if (i_addr == OFF_BASE) begin
        state_next.rd_data = state_reg.base + {11'h000, state_reg.vec_pair, 2'h0};
      end else if (i_addr == OFF_PORTCFG) begin
        state_next.rd_data = state_reg.port_cfg;
      end else if (pidx != 2'h3) begin
        for (int h = 0; h < 2; h++) begin
          state_next.rd_data[h * PC_LANE + PC_TRG_LSB +: TRIG_W] = state_reg.trg_sel[pidx * 2 + h];
          state_next.rd_data[h * PC_LANE + PC_SOFT] = state_reg.soft_trg[pidx * 2 + h];
          state_next.rd_data[h * PC_LANE + PC_PEND] = state_reg.pend[pidx * 2 + h];
          state_next.rd_data[h * PC_LANE + PC_IRQEN] = state_reg.irq_en[pidx * 2 + h];
        end
      end else if (is_result(i_addr)) begin
        rv = result_buffer[result_index(i_addr)];
        if (state_reg.ctrl[CTRL_LAYOUT]) begin
          state_next.rd_data = {rv, 6'h00};
        end else begin
          state_next.rd_data = {6'h00, rv};
        end
      end
    end
  end

  // Control state; the result buffer below is kept out of reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.ctrl <= CTRL_RESET;
      state_reg.base <= BASE_RESET;
      state_reg.port_cfg <= PORTCFG_RESET;
      state_reg.state <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (buf_we) begin
      result_buffer[buf_ch] <= i_conv_result;
    end
  end

  assign o_rd_data = state_reg.rd_data;
  assign o_conv_active = (state_reg.state != ST_IDLE);
  assign o_conv_channel = (state_reg.state != ST_IDLE) ? cur_ch : 4'h0;
  assign o_conv_clock_tick = conv_tick;
  assign o_analog_select = ~state_reg.port_cfg[CHANNELS-1:0];
  assign o_conversion_irq_flag = state_reg.irq;

endmodule // adc_pair_trigger_status_ctrl

/* File: dv/adc_pair_checker.sv */
/* Concurrent checks for the paired converter control block.
   Sees only the top module's ports; bound to it at the foot of this file. */
`timescale 1ns/1ns
module adc_pair_checker
  import adc_pair_pkg::*;
(
  // Watched ports
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [adc_pair_pkg::ADDR_W-1:0] i_addr,
  input wire logic [adc_pair_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [adc_pair_pkg::DATA_W-1:0] o_rd_data,
  input wire logic [adc_pair_pkg::TRIG_SRCS-1:0] i_trigger_sources,
  input wire logic i_cpu_idle,
  input wire logic [adc_pair_pkg::RESULT_W-1:0] i_conv_result,
  input wire logic o_conv_active,
  input wire logic [3:0] o_conv_channel,
  input wire logic o_conv_clock_tick,
  input wire logic [adc_pair_pkg::CHANNELS-1:0] o_analog_select,
  input wire logic o_conversion_irq_flag
);
  logic [15:0] ctl_reg;
  logic [11:0] sel_reg;
  logic [5:0] gap_reg;
  logic seen_reg;
  logic cfg_wr;
  assign cfg_wr = i_wr_en && (i_addr == OFF_PORTCFG);
  // Shadow of software settings and spacing of conversion ticks
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_reg <= 16'h0000;
      sel_reg <= 12'hfff;
      gap_reg <= 6'h00;
      seen_reg <= 1'b0;
    end else begin
      if (i_wr_en && (i_addr == OFF_CTRL)) ctl_reg <= i_wr_data;
      if (cfg_wr) sel_reg <= ~i_wr_data[11:0];
      gap_reg <= o_conv_clock_tick ? 6'h01 : gap_reg + 6'h01;
      seen_reg <= o_conv_active && (seen_reg || o_conv_clock_tick);
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_pair_start;
    !o_conv_active ##1 o_conv_active;
  endsequence
  sequence s_ch_step;
    o_conv_active ##1 (o_conv_active && (o_conv_channel != $past(o_conv_channel)));
  endsequence
  AST_SEL_FOLLOWS: assert property (!cfg_wr ##1 !cfg_wr |=> o_analog_select == sel_reg)
    else $error("analog select differs from port configuration");
  AST_RD_IDLE: assert property (!i_rd_en |=> o_rd_data == 16'h0000)
    else $error("read data not zero outside read answer");
  AST_IRQ_ONE: assert property (o_conversion_irq_flag |=> !o_conversion_irq_flag)
    else $error("interrupt flag longer than one cycle");
  AST_IDLE_STOP: assert property (ctl_reg[15] && ctl_reg[13] && i_cpu_idle |-> ##[0:2] !o_conv_active)
    else $error("conversion continues in idle with stop set");
  AST_POWER_OFF: assert property ((!ctl_reg[15]) [*3] |-> !o_conv_active)
    else $error("conversion active while powered off");
  AST_TICK_GAP: assert property (o_conv_clock_tick && seen_reg
    |-> gap_reg == {2'b00, ctl_reg[2:0], 1'b0} + 6'h04)
    else $error("conversion tick spacing wrong");
  AST_FIRST_CH: assert property (s_pair_start |-> o_conv_channel[0] == ctl_reg[6])
    else $error("pair started on wrong channel");
  AST_CH_STEP: assert property (s_ch_step
    |-> ctl_reg[6] || (o_conv_channel == $past(o_conv_channel) + 4'h1))
    else $error("second channel of pair wrong");
endmodule // adc_pair_checker

bind adc_pair_trigger_status_ctrl adc_pair_checker u_checker (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .i_trigger_sources(i_trigger_sources), .i_cpu_idle(i_cpu_idle),
  .i_conv_result(i_conv_result), .o_conv_active(o_conv_active),
  .o_conv_channel(o_conv_channel), .o_conv_clock_tick(o_conv_clock_tick),
  .o_analog_select(o_analog_select), .o_conversion_irq_flag(o_conversion_irq_flag)
);

/* File: dv/trig_source_model.sv */
/* Far-side model: timer period-match pulse source and analog core result.
   Assumes the bench pulses i_fire for one cycle after a rising edge. */
`timescale 1ns/1ns
module trig_source_model
  import adc_pair_pkg::*;
(
  // Clock, reset and command
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_fire,
  // Converter side
  input wire logic i_conv_active,
  input wire logic [3:0] i_conv_channel,
  output logic [adc_pair_pkg::TRIG_SRCS-1:0] o_trigger_sources,
  output logic [adc_pair_pkg::RESULT_W-1:0] o_conv_result
);
  logic [9:0] junk_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trigger_sources <= '0;
      junk_reg <= 10'h155;
    end else begin
      o_trigger_sources <= TRIG_SRCS'(i_fire) << TRIG_TIMER1_PERIOD;
      junk_reg <= ~junk_reg;
    end
  end
  // Result names the channel; toggling junk outside conversions
  assign o_conv_result = i_conv_active ? {6'h15, i_conv_channel} : junk_reg;
endmodule // trig_source_model

/* File: dv/adc_pair_trigger_status_ctrl_tb.sv */
/* Register-level testbench for the paired converter control block.
   Hardware triggers and results come from the far-side model. */
`timescale 1ns/1ns
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module adc_pair_trigger_status_ctrl_tb;
  import adc_pair_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wr_data = '0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_cpu_idle = 1'b0;
  logic fire = 1'b0;
  logic [DATA_W-1:0] o_rd_data;
  logic [TRIG_SRCS-1:0] trig;
  logic [RESULT_W-1:0] result;
  logic o_conv_active, o_conv_clock_tick, o_conversion_irq_flag;
  logic [3:0] o_conv_channel;
  logic [CHANNELS-1:0] o_analog_select;
  int error_cnt = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_conversion_irq_flag === 1'b1) irq_cnt++;
  adc_pair_trigger_status_ctrl u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_trigger_sources(trig),
    .i_cpu_idle(i_cpu_idle), .i_conv_result(result), .o_conv_active(o_conv_active),
    .o_conv_channel(o_conv_channel), .o_conv_clock_tick(o_conv_clock_tick),
    .o_analog_select(o_analog_select), .o_conversion_irq_flag(o_conversion_irq_flag));
  trig_source_model u_model (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_fire(fire), .i_conv_active(o_conv_active),
    .i_conv_channel(o_conv_channel), .o_trigger_sources(trig), .o_conv_result(result));
  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clock);
    i_rd_en <= 1'b0;
    #1;
    `CHK(o_rd_data, e)
    @(posedge i_clock);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Bounded waits; running out counts a mismatch and ends the run
  task automatic wait_irq();
    int k;
    for (k = 0; k < 2000 && o_conversion_irq_flag !== 1'b1; k++) @(posedge i_clock);
    if (k == 2000) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic wait_done();
    int k;
    idle(4);
    for (k = 0; k < 2000 && o_conv_active !== 1'b0; k++) @(posedge i_clock);
    if (k == 2000) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rdc(OFF_CTRL, CTRL_RESET);
    rdc(OFF_BASE, BASE_RESET);
    rdc(OFF_PORTCFG, PORTCFG_RESET);
    `CHK(o_analog_select, 12'hfff)
    rdc(8'h3c, 16'h0000);
    wr(OFF_PORTCFG, 16'hfffc);
    idle(2);
    `CHK(o_analog_select, 12'h003)
    wr(OFF_STATUS, 16'h0000);
    wr(OFF_BASE, 16'h1000);
    wr(OFF_CTRL, 16'h8005);
    wr(OFF_PAIRCTL, 16'h81a1);
    idle(3);
    rdc(OFF_PAIRCTL, 16'h81c1);
    wait_irq();
    rdc(OFF_STATUS, 16'h0001);
    rdc(OFF_BASE, 16'h1000);
    wait_done();
    rdc(OFF_PAIRCTL, 16'h8181);
    rdc(OFF_RESULT, 16'h0150);
    rdc(8'h44, 16'h0151);
    wr(OFF_PAIRCTL, 16'h81a1);
    wait_done();
    `CHK(irq_cnt, 1)
    wr(OFF_STATUS, 16'h0000);
    rdc(OFF_STATUS, 16'h0000);
    wr(8'h14, 16'h2100);
    wait_done();
    `CHK(irq_cnt, 1)
    rdc(OFF_STATUS, 16'h0008);
    wr(8'h14, 16'h01a1);
    wait_irq();
    rdc(OFF_BASE, 16'h1008);
    wr(OFF_STATUS, 16'h0000);
    wr(OFF_CTRL, 16'h8085);
    wr(OFF_PAIRCTL, 16'h81a1);
    wait_irq();
    `CHK(o_conv_active, 1'b1)
    `CHK(o_conv_channel, 4'h1)
    rdc(OFF_PAIRCTL, 16'h81c1);
    wait_done();
    rdc(OFF_PAIRCTL, 16'h8181);
    `CHK(irq_cnt, 3)
    wr(OFF_STATUS, 16'h0000);
    wr(OFF_CTRL, 16'h8005);
    wr(OFF_PAIRCTL, 16'h8c81);
    fire <= 1'b1;
    @(posedge i_clock);
    fire <= 1'b0;
    wait_irq();
    rdc(OFF_BASE, 16'h1004);
    wait_done();
    wr(OFF_STATUS, 16'h0000);
    wr(8'h18, 16'h0082);
    wr(OFF_CTRL, 16'h8405);
    idle(3);
    rdc(OFF_CTRL, 16'h8005);
    wait_irq();
    rdc(OFF_BASE, 16'h1010);
    wait_done();
    wr(OFF_STATUS, 16'h0000);
    wr(OFF_CTRL, 16'h0005);
    wr(OFF_PAIRCTL, 16'h8ca1);
    idle(3);
    rdc(OFF_PAIRCTL, 16'h8ca1);
    wr(OFF_CTRL, 16'ha005);
    idle(40);
    i_cpu_idle <= 1'b1;
    idle(3);
    `CHK(o_conv_active, 1'b0)
    rdc(OFF_PAIRCTL, 16'h8c81);
    i_cpu_idle <= 1'b0;
    idle(400);
    `CHK(irq_cnt, 5)
    wr(OFF_CTRL, 16'h8005);
    i_cpu_idle <= 1'b1;
    wr(OFF_PAIRCTL, 16'h8ca1);
    wait_irq();
    rdc(OFF_STATUS, 16'h0001);
    i_cpu_idle <= 1'b0;
    wrap_up();
  end
endmodule // adc_pair_trigger_status_ctrl_tb
